// *** rtl/apm_pkg.sv ***
// Notes on behaviour
// RL1 - Normal frame cut in window: partial power-down
// RL2 - Partial frame cut in window: full power-down
// RL3 - Full power-down turns all analog off
// RL4 - Raising select in window suffices, no frame
// RL5 - Dummy frame past tenth edge wakes device
// RL6 - Host waits four ms after full wake
// RL7 - Host waits 4 us or 1 us partial
// RL8 - External reference, slow clock: one dummy
// RL9 - Host keeps quiet gap after each frame
// RL10 - Host stretches select high for wake time
// RL11 - Reference buffers off, internal ones re-powered
// RL12 - Partial wake: track on first clock edge
// RL13 - Unknown start mode: host runs dummy first
// RL14 - Host: two dummies reach partial power-down
// RL15 - Host: three dummies reach full power-down
// RL16 - Sampling stage tracks straight after start-up
// RL17 - Select rise before second edge: stay normal
// RL18 - Aborted partial wake falls back to partial
// RL19 - Ten falling edges keep device powered
// RL20 - Edge counter cleared at select fall
package apm_pkg;
  // Power modes of the converter
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PARTIAL, MODE_FULL} apm_mode_t;
  // Host state machine
  typedef enum logic [1:0] {H_IDLE, H_FRAME, H_GAP} apm_hstate_t;
  // Host commands
  localparam logic CMD_CONVERT = 1'b0;
  localparam logic CMD_POWER_DOWN = 1'b1;
  // Falling edge landmarks within a frame
  localparam logic [5:0] EDGE_MIN = 6'h02;
  localparam logic [5:0] EDGE_WAKE = 6'h0A;
  localparam logic [5:0] EDGE_TRACK = 6'h0D;
  localparam logic [5:0] FRAME_EDGES = 6'h10;
  localparam logic [5:0] DUAL_EDGES = 6'h20;
  localparam logic [5:0] PD_EDGES = 6'h04;
  // Clock rate and timing figures
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  localparam int FULL_WAKE_MS = 4;
  localparam int PART_INT_US = 4;
  localparam int PART_EXT_US = 1;
  localparam int QUIET_GAP_NS = 50;
  localparam int FULL_WAKE_CYC = FULL_WAKE_MS * 1000 * CLK_MHZ;
  localparam logic [17:0] PART_INT_CYC = 18'(PART_INT_US * CLK_MHZ);
  localparam logic [17:0] PART_EXT_CYC = 18'(PART_EXT_US * CLK_MHZ);
  localparam logic [7:0] QUIET_CYC = 8'((QUIET_GAP_NS + CLK_NS - 1) / CLK_NS);
  // Half period of the host serial clock, 6.25 MHz
  localparam logic [7:0] SCLK_HALF_CYC = 8'h04;
  // Values after reset
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_SCLK = 1'b1;
  localparam logic RST_TRACK = 1'b1;
endpackage

// *** rtl/apm_link_if.sv ***
`timescale 1ns/1ps
interface apm_link_if;
  // Frame and clock from the host
  logic cs_n;
  logic sclk;
  // Data lines from the device with their enables
  logic serial_out_a;
  logic serial_out_b;
  logic serial_oe_a;
  logic serial_oe_b;
  modport device (input cs_n, input sclk, output serial_out_a, output serial_out_b,
    output serial_oe_a, output serial_oe_b);
  modport host (output cs_n, output sclk, input serial_out_a, input serial_out_b,
    input serial_oe_a, input serial_oe_b);
endinterface

// *** rtl/apm_device.sv ***
`timescale 1ns/1ps
module apm_device (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Serial link to the host
  apm_link_if.device LINK,
  // Reference strap, high for the internal reference
  input wire logic REF_INTERNAL,
  // Power state view
  output logic [1:0] MODE,
  output logic ANALOG_ON,
  output logic REF_BUF_ON,
  output logic TRACK,
  output logic WAKING
);
  // Synchroniser stages; stage one only feeds stage two
  // The third stage of select and clock exists to see edges; the select one also gives the low level
  logic cs_s1_r; // Select, first stage, may be metastable
  logic cs_s2_r; // Select, settled
  logic cs_s3_r; // Select, one cycle older
  logic ck_s1_r; // Serial clock, first stage
  logic ck_s2_r; // Serial clock, settled
  logic ck_s3_r; // Serial clock, one cycle older
  logic ref_s1_r; // Reference strap, first stage
  logic ref_s2_r; // Reference strap, settled
  // Mode state and frame bookkeeping
  apm_pkg::apm_mode_t mode_r, mode_nxt;
  logic [5:0] cnt_r, cnt_nxt; // Falling edges this frame
  logic waking_r, waking_nxt; // Power-up in progress
  logic first_r, first_nxt; // No clock edge seen yet this frame
  logic track_r, track_nxt; // Sampling stage in track
  logic oe_r, oe_nxt; // Data lines driven
  logic analog_r; // Analog core powered
  logic refbuf_r; // Reference buffers powered

  // Timing seen from the pins:
  //   a pin change reaches stage two after two cycles,
  //   and the edge wires below are true in the third cycle,
  //   so the state registers react three cycles after the pins.
  // Select and clock share the same delay, so their order is kept.
  // The host must leave a few cycles between pin events;
  // otherwise two events could land in one cycle and one is lost.
  // Limitation: the serial clock must stay well below a quarter
  // of the system clock for this sampling to hold.
  // Trade-off: the extra stage costs a cycle of latency but
  // gives clean one-cycle edge pulses from settled samples only.

  // Edge detection on settled samples
  wire cs_fall = cs_s3_r & ~cs_s2_r;
  wire cs_rise = ~cs_s3_r & cs_s2_r;
  wire ck_fall = ck_s3_r & ~ck_s2_r;
  wire ck_rise = ~ck_s3_r & ck_s2_r;
  wire cs_low = ~cs_s3_r;
  // Frame window and saturating fall counter
  wire in_window = (cnt_r >= apm_pkg::EDGE_MIN) && (cnt_r < apm_pkg::EDGE_WAKE);
  wire [5:0] cnt_inc = (cnt_r == apm_pkg::DUAL_EDGES) ? cnt_r : cnt_r + 6'h01;
  // Wake commits on the tenth counted fall, not at the rise
  wire wake_commit = ck_fall && cs_low && (cnt_inc == apm_pkg::EDGE_WAKE);
  wire is_normal = (mode_r == apm_pkg::MODE_NORMAL);

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      // Pins idle high, so no false edge follows reset
      cs_s1_r <= apm_pkg::RST_CS_N;
      cs_s2_r <= apm_pkg::RST_CS_N;
      cs_s3_r <= apm_pkg::RST_CS_N;
      ck_s1_r <= apm_pkg::RST_SCLK;
      ck_s2_r <= apm_pkg::RST_SCLK;
      ck_s3_r <= apm_pkg::RST_SCLK;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= LINK.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ck_s1_r <= LINK.sclk;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      ref_s1_r <= REF_INTERNAL;
      ref_s2_r <= ref_s1_r;
    end
  end

  // Frame classification at the select rise:
  //   fewer than two falls - no mode change, a glitch is ignored
  //   two to nine falls - normal to partial, partial to full
  //   ten or more falls - wake already committed at the tenth fall
  // A waking frame from full that is cut stays in full;
  // that is the safe side, as the host still owes the long wake time.
  // Power-up is requested at the select fall and only kept
  // if the select stays low past the tenth falling edge.
  // The count saturates at thirty-two, the end of a dual read,
  // so a select idling low never wraps back into the window.
  // Mode sequencing; one event handled per cycle
  always_comb begin
    // Hold everything unless an event below says otherwise
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    waking_nxt = waking_r;
    first_nxt = first_r;
    track_nxt = track_r;
    oe_nxt = oe_r;
    if (cs_rise) begin
      // Classify the frame by its edge count [RL20]
      if (in_window) begin
        // Entry needs no remaining clocks [RL4]
        if (is_normal) begin
          mode_nxt = apm_pkg::MODE_PARTIAL; // [RL1]
        end else begin
          mode_nxt = apm_pkg::MODE_FULL; // [RL2]
        end
      end
      // Early rise: normal stays, an aborted wake drops back [RL17] [RL18]
      waking_nxt = 1'b0;
      oe_nxt = 1'b0;
      // Hold while powered down, track otherwise
      track_nxt = (mode_nxt == apm_pkg::MODE_NORMAL);
    end else if (cs_fall) begin
      // Fresh count each frame [RL20]
      cnt_nxt = 6'h00;
      // Power-up starts at the select fall [RL5]
      waking_nxt = !is_normal;
      first_nxt = 1'b1;
      // Sampling stage holds from the select fall
      track_nxt = 1'b0;
      // Data lines leave three-state with the select fall
      oe_nxt = 1'b1;
    end else if (cs_low && (ck_fall || ck_rise)) begin
      // Clock edges only count while the frame is open
      first_nxt = 1'b0;
      // Waking stage returns to track on first edge [RL12]
      if (first_r && waking_r) begin
        track_nxt = 1'b1;
      end
      if (ck_fall) begin
        // Count the fall, saturating at the dual read end
        cnt_nxt = cnt_inc;
        // Low past the tenth edge keeps it up [RL5] [RL19]
        if (wake_commit) begin
          mode_nxt = apm_pkg::MODE_NORMAL;
          waking_nxt = 1'b0;
        end
        // Both results read, lines released
        if (cnt_inc == apm_pkg::DUAL_EDGES) begin
          oe_nxt = 1'b0;
        end
      end else if (is_normal && !waking_r && cnt_r >= apm_pkg::EDGE_TRACK) begin
        // Conversion done with the sample, back to track
        track_nxt = 1'b1;
      end
    end
  end

  // All frame state lives here; the reset values give a powered,
  // tracking device, as a fresh supply may well leave it.
  // The host cannot rely on that and runs a dummy frame anyway,
  // so the choice only matters for the sampling stage.
  // State registers; track at start-up [RL16]
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_r <= apm_pkg::MODE_NORMAL;
      cnt_r <= 6'h00;
      waking_r <= 1'b0;
      first_r <= 1'b0;
      track_r <= apm_pkg::RST_TRACK; // [RL16]
      oe_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      waking_r <= waking_nxt;
      first_r <= first_nxt;
      track_r <= track_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Switches lag the mode by one cycle, which keeps them glitch free.
  // In partial the buffers are off; with an external reference
  // they stay off while waking, which is why that wake is shorter.
  // Power switches follow the registered mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      analog_r <= 1'b1;
      refbuf_r <= 1'b1;
    end else begin
      // Full or partial down: analog off unless waking [RL3]
      analog_r <= (mode_r == apm_pkg::MODE_NORMAL) || waking_r; // [RL3]
      // Buffers off when down; internal reference re-powers them [RL11]
      refbuf_r <= (mode_r == apm_pkg::MODE_NORMAL) || (waking_r && ref_s2_r); // [RL11]
    end
  end

  // Only the output enables carry information on the data lines;
  // the result bits belong to the conversion logic
  // and are held at zero here.
  // Outputs straight from flip-flops; data content is not modelled, lines carry zero
  assign MODE = mode_r;
  assign ANALOG_ON = analog_r;
  assign REF_BUF_ON = refbuf_r;
  assign TRACK = track_r;
  assign WAKING = waking_r;
  assign LINK.serial_out_a = 1'b0;
  assign LINK.serial_out_b = 1'b0;
  assign LINK.serial_oe_a = oe_r;
  assign LINK.serial_oe_b = oe_r;
endmodule // apm_device

// *** rtl/apm_host.sv ***
`timescale 1ns/1ps
module apm_host #(
  parameter int unsigned FULL_WAKE_CYCLES = apm_pkg::FULL_WAKE_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Serial link to the device
  apm_link_if.host LINK,
  // User request
  input wire logic START,
  input wire logic CMD,
  input wire logic REF_INTERNAL,
  // User status
  output logic BUSY,
  output logic DONE,
  output logic [1:0] ASSUMED_MODE,
  output logic MODE_KNOWN
);
  apm_pkg::apm_hstate_t state_r;
  apm_pkg::apm_mode_t belief_r; // Device mode as the host sees it
  logic known_r; // Mode certain since a full frame
  logic cs_r, sclk_r;
  logic [7:0] div_r; // Half-period divider
  logic [7:0] gap_r; // Quiet gap counter
  logic [5:0] edges_r, target_r;
  logic [17:0] wake_r; // Remaining wake-up delay
  logic cmd_r, pend_r, busy_r, done_r;

  // Divider tick and frame end
  wire tick = (div_r == apm_pkg::SCLK_HALF_CYC - 8'h01);
  wire frame_end = tick && sclk_r && (edges_r == target_r);
  wire long_frame = (target_r >= apm_pkg::EDGE_WAKE);
  // A dummy is needed before a conversion unless known normal [RL13]
  wire need_dummy = !known_r || (belief_r != apm_pkg::MODE_NORMAL);
  // Wake time for a waking frame, worst case when unknown [RL6] [RL7]
  wire [17:0] wake_load = (!known_r || belief_r == apm_pkg::MODE_FULL) ? 18'(FULL_WAKE_CYCLES) :
    (belief_r == apm_pkg::MODE_PARTIAL) ? (REF_INTERNAL ? apm_pkg::PART_INT_CYC : apm_pkg::PART_EXT_CYC) :
    18'h00000;
  // Data lines back in three-state; the quiet gap counts from here [RL9]
  wire lines_idle = !LINK.serial_oe_a && !LINK.serial_oe_b;
  wire gap_done = (gap_r == 8'h00) && (wake_r == 18'h00000) && lines_idle;

  // Host sequencing
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= apm_pkg::H_IDLE;
      belief_r <= apm_pkg::MODE_FULL;
      known_r <= 1'b0;
      cs_r <= apm_pkg::RST_CS_N;
      sclk_r <= apm_pkg::RST_SCLK;
      div_r <= 8'h00;
      gap_r <= 8'h00;
      edges_r <= 6'h00;
      target_r <= 6'h00;
      wake_r <= 18'h00000;
      cmd_r <= apm_pkg::CMD_CONVERT;
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (wake_r != 18'h00000 && !(state_r == apm_pkg::H_FRAME && div_r == 8'h00 && edges_r == 6'h00)) begin
        wake_r <= wake_r - 18'h00001;
      end
      case (state_r)
        apm_pkg::H_IDLE: begin
          if (START) begin
            busy_r <= 1'b1;
            cmd_r <= CMD;
            cs_r <= 1'b0;
            div_r <= 8'h00;
            edges_r <= 6'h00;
            state_r <= apm_pkg::H_FRAME;
            // Unknown mode, or a conversion while not known normal: a full dummy first [RL13] [RL14] [RL15]
            if ((CMD == apm_pkg::CMD_CONVERT && need_dummy) || !known_r) begin
              target_r <= apm_pkg::FRAME_EDGES; // [RL19]
              pend_r <= 1'b1;
              wake_r <= wake_load; // [RL6] [RL7] [RL8]
            end else begin
              target_r <= (CMD == apm_pkg::CMD_POWER_DOWN) ? apm_pkg::PD_EDGES : apm_pkg::FRAME_EDGES;
              pend_r <= 1'b0;
            end
          end
        end
        apm_pkg::H_FRAME: begin
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (frame_end) begin
            // Rise at the frame end; a power-down frame rises inside the window [RL4]
            cs_r <= 1'b1;
            gap_r <= apm_pkg::QUIET_CYC; // [RL9]
            state_r <= apm_pkg::H_GAP;
            if (long_frame) begin
              belief_r <= apm_pkg::MODE_NORMAL; // [RL5]
              known_r <= 1'b1;
            end else begin
              belief_r <= (belief_r == apm_pkg::MODE_NORMAL) ? apm_pkg::MODE_PARTIAL : apm_pkg::MODE_FULL;
            end
          end else if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              edges_r <= edges_r + 6'h01;
            end
          end
        end
        apm_pkg::H_GAP: begin
          // Gap only runs once the device has released its lines [RL9]
          if (gap_r != 8'h00 && lines_idle) begin
            gap_r <= gap_r - 8'h01;
          end
          // Select stays high until quiet gap and wake time pass [RL9] [RL10]
          if (gap_done) begin
            if (pend_r) begin
              pend_r <= 1'b0;
              cs_r <= 1'b0;
              div_r <= 8'h00;
              edges_r <= 6'h00;
              target_r <= (cmd_r == apm_pkg::CMD_POWER_DOWN) ? apm_pkg::PD_EDGES : apm_pkg::FRAME_EDGES;
              state_r <= apm_pkg::H_FRAME;
            end else begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= apm_pkg::H_IDLE;
            end
          end
        end
        default: begin
          state_r <= apm_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign LINK.cs_n = cs_r;
  assign LINK.sclk = sclk_r;
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign ASSUMED_MODE = belief_r;
  assign MODE_KNOWN = known_r;
endmodule // apm_host

// *** verif/apm_asserts.sv ***
`timescale 1ns/1ps
module apm_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_oe_a,
  input wire logic serial_oe_b,
  // Device power view
  input wire logic [1:0] MODE,
  input wire logic ANALOG_ON,
  input wire logic REF_BUF_ON,
  input wire logic WAKING
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Serial clock rests high while no frame is open
  a_sclk_idle_high: assert property (cs_n && $past(cs_n, 2) |-> sclk) else $error("sclk low outside frame");
  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:6] (serial_oe_a && serial_oe_b))
    else $error("outputs not enabled");
  a_oe_off_release: assert property ($rose(cs_n) |-> ##[1:6] (!serial_oe_a && !serial_oe_b))
    else $error("outputs not released");
  // Waking powers parts up for a while, so only settled down states count
  a_full_all_dark: assert property (MODE == 2'h2 && $past(MODE) == 2'h2 && !WAKING && !$past(WAKING) |->
    !ANALOG_ON && !REF_BUF_ON) else $error("analog alive in full");
  a_partial_buf_off: assert property (MODE == 2'h1 && $past(MODE) == 2'h1 && !WAKING && !$past(WAKING) |->
    !REF_BUF_ON) else $error("buffers on in partial");
  a_normal_powered: assert property (MODE == 2'h0 && $past(MODE) == 2'h0 && !WAKING |-> ANALOG_ON)
    else $error("analog off in normal");
  a_no_skip_full: assert property ($past(MODE) == 2'h0 |-> MODE != 2'h2) else $error("normal jumped to full");
  a_wake_while_low: assert property (MODE == 2'h0 && $past(MODE) != 2'h0 |-> !cs_n && !$past(cs_n, 3))
    else $error("woke without select");
  // Lines must have rested in three-state before the next select fall
  a_quiet_gap: assert property ($fell(cs_n) |->
    !$past(serial_oe_a) && !$past(serial_oe_a, 2) && !$past(serial_oe_a, 3)) else $error("select fell in quiet gap");
  a_wake_bounded: assert property ($rose(WAKING) |-> ##[1:120] !WAKING) else $error("waking never ends");
endmodule // apm_asserts

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic cmd = 1'b0;
  logic ref_int = 1'b1;
  logic busy, done, known, an_on, rb_on, trk, wak;
  logic [1:0] mode, amode;
  int mismatches = 0;
  int check_count = 0;
  int waited;
  // Shortened full wake for simulation, and one real frame in cycles
  localparam int FULL_WAKE_SIM = 400;
  localparam int FRAME_CYC = int'(apm_pkg::FRAME_EDGES) * 2 * int'(apm_pkg::SCLK_HALF_CYC);
  // The two ends face each other on one link
  apm_link_if i_link();
  apm_host #(.FULL_WAKE_CYCLES(FULL_WAKE_SIM)) i_apm_host (.CLK(clk), .RSTN(rstn), .LINK(i_link.host), .START(start),
    .CMD(cmd), .REF_INTERNAL(ref_int), .BUSY(busy), .DONE(done), .ASSUMED_MODE(amode), .MODE_KNOWN(known));
  apm_device i_apm_device (.CLK(clk), .RSTN(rstn), .LINK(i_link.device), .REF_INTERNAL(ref_int),
    .MODE(mode), .ANALOG_ON(an_on), .REF_BUF_ON(rb_on), .TRACK(trk), .WAKING(wak));
  apm_asserts i_apm_asserts (.CLK(clk), .RSTN(rstn), .cs_n(i_link.cs_n), .sclk(i_link.sclk),
    .serial_oe_a(i_link.serial_oe_a), .serial_oe_b(i_link.serial_oe_b), .MODE(mode), .ANALOG_ON(an_on),
    .REF_BUF_ON(rb_on), .WAKING(wak));
  // 50 MHz clock
  always #10 clk = ~clk;
  // Compare two-bit results, unknowns never match
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One host request, waits for its done pulse; device lags the pins a few cycles
  task automatic run_cmd(input logic c);
    @(negedge clk);
    cmd = c;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    waited = 0;
    while (done !== 1'b1 && waited < 5000) begin
      @(negedge clk);
      waited++;
    end
    if (waited >= 5000) begin
      mismatches++;
      $display("wrong value done expected 1 seen 0");
    end
    chk("busy", 2'h0, {1'b0, busy});
    repeat (8) @(negedge clk);
  endtask
  // Unknown start mode: dummy frame then conversion
  task automatic t_start_dummy();
    run_cmd(apm_pkg::CMD_CONVERT);
    chk("mode", 2'h0, mode);
    chk("analog", 2'h1, {1'b0, an_on});
    chk("known", 2'h1, {1'b0, known});
    $display("start dummy test done");
  endtask
  // Two cut frames walk normal to partial to full
  task automatic t_power_down();
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h1, mode);
    chk("refbuf", 2'h0, {1'b0, rb_on});
    chk("assumed", 2'h1, amode);
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h2, mode);
    chk("analog", 2'h0, {1'b0, an_on});
    $display("power down test done");
  endtask
  // Full wake with internal reference waits the long time
  task automatic t_wake_full();
    ref_int = 1'b1;
    run_cmd(apm_pkg::CMD_CONVERT);
    chk("mode", 2'h0, mode);
    chk("refbuf", 2'h1, {1'b0, rb_on});
    chk("long wait", 2'h1, {1'b0, waited >= FULL_WAKE_SIM + FRAME_CYC});
    $display("full wake test done");
  endtask
  // External reference partial wake with a single dummy
  task automatic t_wake_ext();
    ref_int = 1'b0;
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h1, mode);
    run_cmd(apm_pkg::CMD_CONVERT);
    chk("mode", 2'h0, mode);
    chk("track", 2'h1, {1'b0, trk});
    $display("external wake test done");
  endtask
  // Internal reference partial wake stretches the select high time
  task automatic t_wake_int();
    ref_int = 1'b1;
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h1, mode);
    run_cmd(apm_pkg::CMD_CONVERT);
    chk("mode", 2'h0, mode);
    chk("refbuf", 2'h1, {1'b0, rb_on});
    chk("wake wait", 2'h1, {1'b0, waited >= int'(apm_pkg::PART_INT_CYC) + FRAME_CYC});
    $display("internal wake test done");
  endtask
  // Mid-run reset, then start-up sequences down to partial and full
  task automatic t_restart();
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("known", 2'h0, {1'b0, known});
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h1, mode);
    run_cmd(apm_pkg::CMD_POWER_DOWN);
    chk("mode", 2'h2, mode);
    chk("assumed", 2'h2, amode);
    $display("restart test done");
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("track", 2'h1, {1'b0, trk});
    t_start_dummy();
    t_power_down();
    t_wake_full();
    t_wake_ext();
    t_wake_int();
    t_restart();
    give_verdict();
  end
  // Watchdog: all tests need well under 5000 cycles
  initial begin
    #(20 * 20000);
    mismatches++;
    give_verdict();
  end
endmodule // tb_top
